/* File: hdl/bgst_pkg.sv */
// Shared constants and types of the bandgap monitor and comparator self-test
package bgst_pkg;

    // ------------------------------------------------------------------
    // Rail counts and timing
    // ------------------------------------------------------------------
    localparam int BUCK_N         = 7;      // Buck outputs under watch
    localparam int LIN_N          = 4;      // Linear outputs under watch
    localparam int CLK_MHZ        = 100;    // Clock rate in MHz
    localparam int SETTLE_US      = 10;     // Settle time per test step
    localparam int BLANK_MAX_US   = 200;    // Longest monitor blanking
    localparam int SETTLE_CYC     = SETTLE_US * CLK_MHZ;
    localparam int BLANK_MAX_CYC  = BLANK_MAX_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;  // Run request
    localparam logic [7:0] OFS_UNLOCK = 8'h01;  // Secure write key
    localparam logic [7:0] OFS_STATUS = 8'h02;  // Live and sticky status
    localparam logic [7:0] OFS_MASK   = 8'h03;  // Interrupt mask
    localparam logic [7:0] OFS_BOV    = 8'h04;  // Buck overvolt results
    localparam logic [7:0] OFS_LOV    = 8'h05;  // Linear overvolt results
    localparam logic [7:0] OFS_BUV    = 8'h06;  // Buck undervolt results
    localparam logic [7:0] OFS_LUV    = 8'h07;  // Linear undervolt results

    // ------------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------------
    localparam int CTRL_RUN_BIT   = 0;
    localparam int STAT_SENSE_BIT = 0;
    localparam int STAT_IRQ_BIT   = 1;
    localparam int MASK_BG_BIT    = 0;
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;  // Arms one secure write
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;   // Register offset
        logic [7:0] wdata;  // Write data
        logic       wr;     // Write strobe
        logic       rd;     // Read strobe
    } bgst_bus_type;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OV_HI, ST_OV_LO, ST_UV_HI, ST_UV_LO, ST_FINISH
    } bgst_state_type;

endpackage

/* File: hdl/bgst_timer.sv */
// One-shot step timer for the comparator self-test
`timescale 1ns/1ps
`default_nettype none
module bgst_timer
    import bgst_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        load,      // Restart the count
    input  wire logic [15:0] load_val,  // Cycles until done
    output logic             done       // One-cycle pulse at expiry
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cnt;   // Cycles left
        logic        run;   // Counting
        logic        done;  // Expiry pulse
    } bgst_tmr_type;

    bgst_tmr_type s_q;
    bgst_tmr_type s_d;

    // Next state: load beats a running count
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (load) begin
            s_d.cnt = load_val;
            s_d.run = 1'b1;
        end else if (s_q.run) begin
            if (s_q.cnt <= 16'h0001) begin
                s_d.run  = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 16'h0001;
            end
        end
    end

    // Register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
endmodule
`default_nettype wire

/* File: hdl/bgst_toggle_chk.sv */
// Records whether each comparator of a rail group toggled both ways
`timescale 1ns/1ps
`default_nettype none
module bgst_toggle_chk #(
    parameter int W = 4
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         clear,      // Start of a new test
    input  wire logic         sample_hi,  // Trip expected now
    input  wire logic         sample_lo,  // Release expected now
    input  wire logic [W-1:0] trip,       // Comparator outputs
    output logic      [W-1:0] fail        // Rail did not toggle
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] hi;  // Seen tripped
        logic [W-1:0] lo;  // Seen released
    } bgst_chk_type;

    bgst_chk_type s_q;
    bgst_chk_type s_d;

    // Per-rail capture
    always_comb begin
        s_d = s_q;
        if (clear) begin
            s_d = '0;
        end
        if (sample_hi) begin
            s_d.hi = trip;
        end
        if (sample_lo) begin
            s_d.lo = ~trip;
        end
    end

    // Register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // A stuck comparator misses one of the two levels
    assign fail = ~(s_q.hi & s_q.lo);
endmodule
`default_nettype wire

/* File: hdl/bgst_core.sv */
// Bandgap monitor, comparator self-test sequencer and register file
//
// How it works
// - Bandgap mismatch blocks switching regulator power-up
// - Bandgap fault at power-up fails test, refuses
// - System-on drift without bypass shuts power stages
// - System-on drift with bypass only interrupts and inhibits switchers
// - Bandgap fault flag set unless masked
// - Sense bit follows live bandgap comparison
// - Test exercises every overvoltage comparator
// - Test exercises every undervoltage comparator
// - Non-toggling comparator sets its rail bit
// - Every test overwrites all result registers
// - Result clear needs secure write when enabled
// - Power-up continues after test; results readable
// - Writing run request starts full test
// - Run request self-clears when test completes
// - Monitor blanking lasts at most 200 us
// - On-demand failures set per-rail flags
`timescale 1ns/1ps
`default_nettype none
module bgst_core
    import bgst_pkg::*;
#(
    parameter logic [15:0] BLANK_LIMIT_CYC = 16'(BLANK_MAX_CYC)
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        bus_addr,
    input  wire logic [7:0]        bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic      [7:0]        bus_rdata,
    input  wire logic              bandgap_mismatch,
    input  wire logic              bandgap_check_bypass_cfg,
    input  wire logic              secure_write_enable,
    input  wire logic              system_on,
    input  wire logic              powerup_request,
    input  wire logic [BUCK_N-1:0] buck_ov_trip,
    input  wire logic [LIN_N-1:0]  linear_ov_trip,
    input  wire logic [BUCK_N-1:0] buck_uv_trip,
    input  wire logic [LIN_N-1:0]  linear_uv_trip,
    output logic                   force_ov,
    output logic                   force_uv,
    output logic                   monitor_blank,
    output logic                   switcher_inhibit,
    output logic                   power_stage_shutdown,
    output logic                   powerup_proceed,
    output logic                   powerup_fail,
    output logic                   bandgap_fault_irq
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        bgst_state_type    st;        // Sequencer state
        logic              pu_mode;   // Test launched by power-up
        logic              run;       // Run request bit
        logic              armed;     // Secure write pending
        logic              irq_flag;  // Sticky bandgap fault
        logic              mask;      // Bandgap interrupt mask
        logic              bg_seen;   // Fault seen during test
        logic              pu_fail;   // Power-up refused
        logic              proceed;   // Power-up go pulse
        logic              shutdown;  // Power stages off
        logic              inhibit;   // Switchers held off
        logic              f_ov;      // Overvolt force
        logic              f_uv;      // Undervolt force
        logic              blank;     // Monitoring blanked
        logic [15:0]       bcnt;      // Blanking length
        logic [BUCK_N-1:0] bov;       // Buck overvolt fails
        logic [LIN_N-1:0]  lov;       // Linear overvolt fails
        logic [BUCK_N-1:0] buv;       // Buck undervolt fails
        logic [LIN_N-1:0]  luv;       // Linear undervolt fails
        logic [7:0]        rdata;     // Read data
        logic              irq_out;   // Gated interrupt
    } bgst_core_type;

    bgst_core_type s_q;
    bgst_core_type s_d;
    bgst_bus_type  bus;

    logic              tmr_load;   // Step timer restart
    logic              tmr_done;   // Step elapsed
    logic              chk_clear;  // New test begins
    logic              ov_hi;      // Sample tripped, overvolt
    logic              ov_lo;      // Sample released, overvolt
    logic              uv_hi;      // Sample tripped, undervolt
    logic              uv_lo;      // Sample released, undervolt
    logic              abort;      // Blanking limit reached
    logic              sec_ok;     // Protected write allowed
    logic              start;      // Launch a test
    logic              run_wr;     // Accepted run request
    logic [BUCK_N-1:0] bov_fail;
    logic [LIN_N-1:0]  lov_fail;
    logic [BUCK_N-1:0] buv_fail;
    logic [LIN_N-1:0]  luv_fail;

    assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    bgst_timer u_tmr (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .load     (tmr_load),
        .load_val (16'(SETTLE_CYC)),
        .done     (tmr_done)
    );

    bgst_toggle_chk #(.W(BUCK_N)) u_bov (
        .mclk (mclk), .rst_n (rst_n), .clear (chk_clear),
        .sample_hi (ov_hi), .sample_lo (ov_lo),
        .trip (buck_ov_trip), .fail (bov_fail)
    );
    bgst_toggle_chk #(.W(LIN_N)) u_lov (
        .mclk (mclk), .rst_n (rst_n), .clear (chk_clear),
        .sample_hi (ov_hi), .sample_lo (ov_lo),
        .trip (linear_ov_trip), .fail (lov_fail)
    );
    bgst_toggle_chk #(.W(BUCK_N)) u_buv (
        .mclk (mclk), .rst_n (rst_n), .clear (chk_clear),
        .sample_hi (uv_hi), .sample_lo (uv_lo),
        .trip (buck_uv_trip), .fail (buv_fail)
    );
    bgst_toggle_chk #(.W(LIN_N)) u_luv (
        .mclk (mclk), .rst_n (rst_n), .clear (chk_clear),
        .sample_hi (uv_hi), .sample_lo (uv_lo),
        .trip (linear_uv_trip), .fail (luv_fail)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.proceed = 1'b0;
        tmr_load  = 1'b0;
        chk_clear = 1'b0;
        ov_hi     = 1'b0;
        ov_lo     = 1'b0;
        uv_hi     = 1'b0;
        uv_lo     = 1'b0;
        // Key holder may make exactly one protected write
        sec_ok    = !secure_write_enable || s_q.armed;
        // Busy sequencer drops new requests
        run_wr    = bus.wr && bus.addr == OFS_CTRL && bus.wdata[CTRL_RUN_BIT]
                    && sec_ok && s_q.st == ST_IDLE;
        start     = run_wr || (powerup_request && s_q.st == ST_IDLE);
        abort     = s_q.blank && s_q.bcnt >= BLANK_LIMIT_CYC - 16'h0001;

        // Secure key handling: any other write spends the key
        if (bus.wr) begin
            s_d.armed = bus.addr == OFS_UNLOCK && bus.wdata == UNLOCK_KEY;
        end

        // Register writes
        if (bus.wr && bus.addr == OFS_MASK) begin
            s_d.mask = bus.wdata[MASK_BG_BIT];
        end
        if (bus.wr && bus.addr == OFS_STATUS && bus.wdata[STAT_IRQ_BIT]) begin
            s_d.irq_flag = 1'b0;
        end
        if (bus.wr && sec_ok) begin
            // Write one to clear a result bit
            case (bus.addr)
                OFS_BOV: s_d.bov = s_q.bov & ~bus.wdata[BUCK_N-1:0];
                OFS_LOV: s_d.lov = s_q.lov & ~bus.wdata[LIN_N-1:0];
                OFS_BUV: s_d.buv = s_q.buv & ~bus.wdata[BUCK_N-1:0];
                OFS_LUV: s_d.luv = s_q.luv & ~bus.wdata[LIN_N-1:0];
                default: ;
            endcase
        end

        // Bandgap monitor: a new event beats a clear in the same cycle
        if (bandgap_mismatch && !s_q.mask) begin
            s_d.irq_flag = 1'b1;
        end
        s_d.irq_out = s_d.irq_flag;
        s_d.inhibit = bandgap_mismatch || s_d.pu_fail;
        if (!system_on) begin
            s_d.shutdown = 1'b0;
        end else if (bandgap_mismatch && !bandgap_check_bypass_cfg) begin
            s_d.shutdown = 1'b1;
        end
        if (s_q.st != ST_IDLE && bandgap_mismatch) begin
            s_d.bg_seen = 1'b1;
        end

        // Blanking length guard
        if (s_q.blank) begin
            s_d.bcnt = s_q.bcnt + 16'h0001;
        end

        // Sequencer
        case (s_q.st)
            ST_IDLE: begin
                if (start) begin
                    chk_clear   = 1'b1;
                    tmr_load    = 1'b1;
                    s_d.run     = run_wr;
                    s_d.pu_mode = !run_wr;
                    s_d.bg_seen = bandgap_mismatch;
                    s_d.f_ov    = 1'b1;
                    // Only on-demand tests blank a live system
                    s_d.blank   = run_wr;
                    s_d.bcnt    = 16'h0000;
                    s_d.st      = ST_OV_HI;
                    if (!run_wr) begin
                        s_d.pu_fail = 1'b0;
                    end
                end
            end
            ST_OV_HI: begin
                if (tmr_done) begin
                    ov_hi    = 1'b1;
                    tmr_load = 1'b1;
                    s_d.f_ov = 1'b0;
                    s_d.st   = ST_OV_LO;
                end
            end
            ST_OV_LO: begin
                if (tmr_done) begin
                    ov_lo    = 1'b1;
                    tmr_load = 1'b1;
                    s_d.f_uv = 1'b1;
                    s_d.st   = ST_UV_HI;
                end
            end
            ST_UV_HI: begin
                if (tmr_done) begin
                    uv_hi    = 1'b1;
                    tmr_load = 1'b1;
                    s_d.f_uv = 1'b0;
                    s_d.st   = ST_UV_LO;
                end
            end
            ST_UV_LO: begin
                if (tmr_done) begin
                    uv_lo  = 1'b1;
                    s_d.st = ST_FINISH;
                end
            end
            ST_FINISH: begin
                // Fresh outcome overrides any clear this cycle
                s_d.bov   = bov_fail;
                s_d.lov   = lov_fail;
                s_d.buv   = buv_fail;
                s_d.luv   = luv_fail;
                s_d.run   = 1'b0;
                s_d.blank = 1'b0;
                s_d.st    = ST_IDLE;
                if (s_q.pu_mode) begin
                    if (s_q.bg_seen || bandgap_mismatch) begin
                        s_d.pu_fail = 1'b1;
                    end else begin
                        s_d.proceed = 1'b1;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase

        // Stop early rather than overrun the blanking window
        if (abort && s_q.st != ST_FINISH) begin
            s_d.f_ov  = 1'b0;
            s_d.f_uv  = 1'b0;
            s_d.blank = 1'b0;
            s_d.st   = ST_FINISH;
        end

        // Read data, valid only the cycle after the strobe
        s_d.rdata = RESET_BYTE;
        if (bus.rd) begin
            case (bus.addr)
                OFS_CTRL:   s_d.rdata = {7'h00, s_q.run};
                OFS_UNLOCK: s_d.rdata = {7'h00, s_q.armed};
                OFS_STATUS: s_d.rdata = {3'h0, s_q.shutdown, s_q.pu_fail,
                                         s_q.st != ST_IDLE, s_q.irq_flag,
                                         bandgap_mismatch};
                OFS_MASK:   s_d.rdata = {7'h00, s_q.mask};
                OFS_BOV:    s_d.rdata = {1'b0, s_q.bov};
                OFS_LOV:    s_d.rdata = {4'h0, s_q.lov};
                OFS_BUV:    s_d.rdata = {1'b0, s_q.buv};
                OFS_LUV:    s_d.rdata = {4'h0, s_q.luv};
                default:    s_d.rdata = RESET_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q    <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_rdata            = s_q.rdata;
    assign force_ov             = s_q.f_ov;
    assign force_uv             = s_q.f_uv;
    assign monitor_blank        = s_q.blank;
    assign switcher_inhibit     = s_q.inhibit;
    assign power_stage_shutdown = s_q.shutdown;
    assign powerup_proceed      = s_q.proceed;
    assign powerup_fail         = s_q.pu_fail;
    assign bandgap_fault_irq    = s_q.irq_out;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence seq_ov_step;
        force_ov [*8] ##[1:1000] !force_ov;
    endsequence
    sequence seq_uv_step;
        force_uv [*8] ##[1:1000] !force_uv;
    endsequence

    a_inhibit_on_gap: assert property (bandgap_mismatch |=> switcher_inhibit)
        else $error("mismatch did not inhibit switchers");
    a_pu_refused: assert property ((s_q.st == ST_FINISH && s_q.pu_mode && bandgap_mismatch)
        |=> powerup_fail && !powerup_proceed)
        else $error("power-up not refused on bandgap fault");
    a_drift_shutdown: assert property ((system_on && bandgap_mismatch
        && !bandgap_check_bypass_cfg) |=> power_stage_shutdown)
        else $error("drift did not shut power stages");
    a_bypass_irq_only: assert property ((system_on && bandgap_mismatch
        && bandgap_check_bypass_cfg && !s_q.shutdown && !s_q.mask)
        |=> !power_stage_shutdown ##1 bandgap_fault_irq)
        else $error("bypass drift handled wrongly");
    a_flag_unmasked: assert property ((bandgap_mismatch && !s_q.mask)
        |=> s_q.irq_flag)
        else $error("bandgap flag not set");
    a_sense_read: assert property ((bus_rd && bus_addr == OFS_STATUS)
        |=> bus_rdata[STAT_SENSE_BIT] == $past(bandgap_mismatch))
        else $error("sense bit not live");
    a_ov_step: assert property ($rose(force_ov) |-> seq_ov_step)
        else $error("overvolt step malformed");
    a_uv_follows: assert property ((s_q.st == ST_OV_LO && tmr_done && !abort) |=> seq_uv_step)
        else $error("undervolt step missing");
    a_result_write: assert property ((s_q.st == ST_FINISH)
        |=> s_q.bov == $past(bov_fail) && s_q.luv == $past(luv_fail))
        else $error("results not overwritten");
    a_secure_clear: assert property ((secure_write_enable && !s_q.armed && bus_wr
        && s_q.st != ST_FINISH) |=> $stable(s_q.bov) && $stable(s_q.lov))
        else $error("result cleared without secure write");
    a_run_clears: assert property ((s_q.st == ST_FINISH) |=> !s_q.run)
        else $error("run request did not self-clear");
    a_blank_bound: assert property (monitor_blank |-> s_q.bcnt < BLANK_LIMIT_CYC)
        else $error("blanking too long");
    a_busy_ignore: assert property ((s_q.st == ST_UV_LO && !tmr_done && !abort)
        |=> s_q.st == ST_UV_LO)
        else $error("test restarted while busy");
endmodule
`default_nettype wire

/* File: verification/bgst_cmp_model.sv */
// Behavioural comparator bank that answers the self-test force lines
`timescale 1ns/1ps
`default_nettype none
module bgst_cmp_model
    import bgst_pkg::*;
(
    input  wire logic              force_ov,
    input  wire logic              force_uv,
    input  wire logic [BUCK_N-1:0] buck_stuck,  // Rails whose comparator is dead
    input  wire logic [LIN_N-1:0]  lin_stuck,
    output logic      [BUCK_N-1:0] buck_ov,
    output logic      [LIN_N-1:0]  lin_ov,
    output logic      [BUCK_N-1:0] buck_uv,
    output logic      [LIN_N-1:0]  lin_uv
);
    // ------------------------------------------------------------------
    // Trip follows the force line; a stuck rail never toggles
    // ------------------------------------------------------------------
    assign buck_ov = {BUCK_N{force_ov}} & ~buck_stuck;
    assign lin_ov  = {LIN_N{force_ov}} & ~lin_stuck;
    assign buck_uv = {BUCK_N{force_uv}} & ~buck_stuck;
    assign lin_uv  = {LIN_N{force_uv}} & ~lin_stuck;
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench of the bandgap monitor and comparator self-test
`timescale 1ns/1ps
`default_nettype none
module tb
    import bgst_pkg::*;
;
    logic              mclk = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    logic [7:0]        bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, rv;
    logic              mis = 1'b0, byp = 1'b0, swe = 1'b0, son = 1'b0, pur = 1'b0;
    logic              fov, fuv, blank, inh, shut, proc, pfail, irq;
    logic [BUCK_N-1:0] bov, buv, bstk = '0;  // Model: dead buck comparators
    logic [LIN_N-1:0]  lov, luv, lstk = '0;  // Model: dead linear comparators
    logic [15:0]       seed = 16'hDE0A;
    int                n_errors = 0, checks_done = 0;

    // ------------------------------------------------------------------
    // Clock and parts
    // ------------------------------------------------------------------
    initial forever #5 mclk = ~mclk;
    // Short blanking limit keeps the run brief but above the test length
    bgst_core #(.BLANK_LIMIT_CYC(16'h1388)) i_dut (.mclk(mclk), .rst_n(rst_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .bandgap_mismatch(mis), .bandgap_check_bypass_cfg(byp),
        .secure_write_enable(swe), .system_on(son), .powerup_request(pur),
        .buck_ov_trip(bov), .linear_ov_trip(lov), .buck_uv_trip(buv),
        .linear_uv_trip(luv), .force_ov(fov), .force_uv(fuv), .monitor_blank(blank),
        .switcher_inhibit(inh), .power_stage_shutdown(shut), .powerup_proceed(proc),
        .powerup_fail(pfail), .bandgap_fault_irq(irq));
    bgst_cmp_model i_cmp (.force_ov(fov), .force_uv(fuv), .buck_stuck(bstk),
        .lin_stuck(lstk), .buck_ov(bov), .lin_ov(lov), .buck_uv(buv), .lin_uv(luv));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_wr <= 1'b1; bus_addr <= a; bus_wdata <= d;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus_rd <= 1'b1; bus_addr <= a;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;  // Data stand only in this cycle
    endtask
    task automatic swr(input logic [7:0] a, input logic [7:0] d);
        wr(OFS_UNLOCK, UNLOCK_KEY);  // Key arms exactly the next write
        wr(a, d);
    endtask
    // Next value of the fault pattern generator
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // New random set of dead comparators for the next test
    task automatic new_faults;
        seed = lfsr_next(seed);
        @(posedge mclk);
        bstk <= seed[6:0]; lstk <= seed[10:7];
    endtask
    // Bounded wait for test end, then compare all four result registers
    task automatic results(input bit od);
        for (int i = 0; i <= 6000; i++) begin
            @(posedge mclk); #1;
            if (od ? blank === 1'b0 : (proc === 1'b1 || pfail === 1'b1)) break;
            if (i == 6000) begin
                n_errors++;
                $display("Error self-test end never seen");
                tally_and_finish;
            end
        end
        for (int i = 0; i < 4; i++) begin
            rd(OFS_BOV + 8'(i), rv);
            chk("result", (i % 2 == 0) ? 8'(bstk) : 8'(lstk), rv);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rd(OFS_STATUS, rv); chk("status", RESET_BYTE, rv);
        new_faults;
        @(posedge mclk) pur <= 1'b1;
        @(posedge mclk) pur <= 1'b0;
        results(1'b0);
        chk("pfail", 8'h00, 8'(pfail));
        new_faults;
        swe <= 1'b1;
        wr(OFS_CTRL, 8'h01); rd(OFS_STATUS, rv); chk("busy", 8'h00, 8'(rv[2]));
        // System is off here, so blanking the monitors is safe
        swr(OFS_CTRL, 8'h01); rd(OFS_CTRL, rv); chk("run", 8'h01, rv);
        chk("blank", 8'h01, 8'(blank));
        swr(OFS_CTRL, 8'h01);
        results(1'b1);
        rd(OFS_CTRL, rv); chk("run", 8'h00, rv);
        wr(OFS_BOV, 8'hFF); rd(OFS_BOV, rv); chk("plain clr", 8'(bstk), rv);
        swr(OFS_BOV, 8'hFF); rd(OFS_BOV, rv); chk("secure clr", 8'h00, rv);
        // Drift in system-on, without and with bypass
        for (int b = 0; b < 2; b++) begin
            @(posedge mclk) begin son <= 1'b1; byp <= b[0]; mis <= 1'b1; end
            rd(OFS_STATUS, rv); chk("sense", 8'h01, 8'(rv[0]));
            chk("irq", 8'h01, 8'(irq));
            chk("shutdown", 8'(b == 0), 8'(shut));
            chk("inhibit", 8'h01, 8'(inh));
            @(posedge mclk) begin mis <= 1'b0; son <= 1'b0; end
            wr(OFS_STATUS, 8'h02);
            rd(OFS_STATUS, rv); chk("sense", 8'h00, 8'(rv[1:0]));
        end
        wr(OFS_MASK, 8'h01);
        @(posedge mclk) mis <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("masked irq", 8'h00, 8'(irq));
        // Fault present at power-up, bypass still set
        pur <= 1'b1;
        @(posedge mclk) pur <= 1'b0;
        results(1'b0);
        chk("pfail", 8'h01, 8'(pfail));
        tally_and_finish;
    end
endmodule
`default_nettype wire
